/* File: verilog/i2c10_regs.svh */
// Register map, field positions, reset values and timing for the 10-bit I2C link pair
`ifndef I2C10_REGS_SVH
`define I2C10_REGS_SVH

`define REG_AW 2
`define REG_DW 16

// Receiving end register offsets
`define REG_ADDR_MATCH 2'h0
`define REG_CONTROL 2'h1
`define REG_STATUS 2'h2
`define REG_RX_BUF 2'h3

// Control field positions
`define CTL_STRETCH 0
`define CTL_ADDR_HOLD 1
`define CTL_DATA_HOLD 2
`define CTL_START_IE 3
`define CTL_CLK_RELEASE 4

// Status field positions
`define ST_IF 0
`define ST_UA 1
`define ST_BF 2
`define ST_START 3
`define ST_STOP 4

// Reset values
`define ADDR_MATCH_RESET 8'hf0
`define CTL_RESET 5'h10

// High address byte: 11110, A9, A8, then direction
`define HI_ADDR_PATTERN 5'h1e

// Bit counter marks: eight data bits, then the acknowledge clock
`define BIT_ACK 4'h8
`define BIT_ACK_END 4'h9

// Sending end register offsets and fields
`define MREG_CMD 2'h0
`define MREG_STATUS 2'h1
`define CMD_START 8
`define CMD_STOP 9
`define MST_BUSY 0
`define MST_NACK 1
`define MST_HOLD 2

// Timing
`define CLK_PERIOD_NS 25
`define LINK_PERIOD_NS 200
`define HALF_CYCLES (`LINK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

`endif

/* File: verilog/i2c10_pkg.sv */
// Shared state types for both ends of the 10-bit I2C link
`default_nettype none
package i2c10_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_ADDR_HI, DEV_ADDR_LO, DEV_DATA} dev_state_t;
  typedef enum logic [3:0] {
    M_IDLE, M_RSTART, M_START, M_SHOLD, M_LOW, M_HIGH, M_END, M_STOP, M_HOLD
  } mst_state_t;
endpackage
`default_nettype wire

/* File: verilog/i2c10_link_if.sv */
// Open-drain SCL and SDA wires joining the bus master and the receiving end
`default_nettype none
interface i2c10_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: any enabled driver at zero pulls the line low
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (mst_scl_oe & ~mst_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (mst_sda_oe & ~mst_sda_o));

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
               output dev_sda_o, output dev_sda_oe);
  modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe,
               output mst_sda_o, output mst_sda_oe);
endinterface
`default_nettype wire

/* File: verilog/i2c10_slave_end.sv */
// Receiving end: 10-bit address match, flags, stretching, receive FIFO
// Notes on behaviour
// RULE_01 - Start sets start bit, optional interrupt flag
// RULE_02 - Matched high byte, write: flag, ack, interrupt
// RULE_03 - Interrupt flag raised after acknowledging address byte
// RULE_04 - Reading receive buffer returns byte, clears full (code: BF stays set until the read empties the FIFO)
// RULE_05 - SCL held after address until address write
// RULE_06 - Software waits for ack before address write
// RULE_07 - Matched low byte: flag, ack, interrupt
// RULE_08 - Low mismatch: flags set, buffer empty, release untouched
// RULE_09 - Software reloads high address after low match
// RULE_10 - Data byte acked on ninth clock, then interrupt
// RULE_11 - Stretch enable clears release bit after byte
// RULE_12 - Software sets release bit after reading byte
// RULE_13 - Byte sequence repeats until master Stop
// RULE_14 - Address and data hold behave as seven-bit
// RULE_15 - High byte is 11110, A9, A8, direction
`default_nettype none
`include "i2c10_regs.svh"

module i2c10_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] fill;

  // Extra pointer bit tells full from empty
  assign fill = wr_ptr - rd_ptr;
  assign in_ready_out = fill != (AW+1)'(DEPTH);
  assign out_valid_out = fill != '0;
  assign out_data_out = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge ref_clk_in)
  begin
    if (in_valid_in && in_ready_out)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid_in && in_ready_out)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid_out && out_ready_in)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // i2c10_fifo

module i2c10_slave_end #(
  parameter logic [7:0] ADDR_RESET = `ADDR_MATCH_RESET,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [`REG_AW-1:0] reg_addr_in,
  input wire logic [`REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`REG_DW-1:0] reg_rdata_out,
  i2c10_link_if.dev link
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  i2c10_pkg::dev_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic ack_drive;
  logic [7:0] address_match_reg;
  logic stretch_enable;
  logic address_hold_enable;
  logic data_hold_enable;
  logic start_ie;
  logic clock_release_bit;
  logic ua_wait;
  logic port_interrupt_flag;
  logic update_address_flag;
  logic start_flag;
  logic stop_flag;
  logic push_pending;
  logic [7:0] push_data;
  logic scl_drv;
  logic fifo_in_ready;
  logic [7:0] fifo_data;
  logic buffer_full_flag;
  logic buf_pop;

  // Two flops per pin before any logic; edges come from the second stage onward
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_fall;
  logic ack_fall;
  logic hi_match;
  logic lo_match;
  logic is_addr;
  logic acked_now;
  logic hold_now;
  logic lo_miss;

  assign scl_rise = scl_sync[1] & ~scl_q;
  assign scl_fall = ~scl_sync[1] & scl_q;
  assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_det = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  assign byte_fall = scl_fall && (bit_cnt == `BIT_ACK);
  assign ack_fall = scl_fall && (bit_cnt == `BIT_ACK_END);

  // High byte needs the fixed prefix, A9:A8 as programmed and a write direction
  assign hi_match = (shift[7:3] == `HI_ADDR_PATTERN) // RULE_15
                    && (shift[2:1] == address_match_reg[2:1]) && !shift[0]; // RULE_02
  assign lo_match = shift == address_match_reg; // RULE_07
  assign is_addr = (state == i2c10_pkg::DEV_ADDR_HI) || (state == i2c10_pkg::DEV_ADDR_LO);
  assign acked_now = ((state == i2c10_pkg::DEV_ADDR_HI) && hi_match)
                     || ((state == i2c10_pkg::DEV_ADDR_LO) && lo_match)
                     || (state == i2c10_pkg::DEV_DATA);
  // Hold modes stop the clock before the ack, as in seven-bit reception
  assign hold_now = byte_fall && acked_now
                    && ((is_addr && address_hold_enable) // RULE_14
                    || ((state == i2c10_pkg::DEV_DATA) && data_hold_enable));
  assign lo_miss = byte_fall && (state == i2c10_pkg::DEV_ADDR_LO) && !lo_match;

  // Byte framing: shift on rising SCL, decide ack after the eighth bit
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= i2c10_pkg::DEV_IDLE;
      bit_cnt <= '0;
      shift <= '0;
      ack_drive <= 1'b0;
    end
    else if (start_det)
    begin
      state <= i2c10_pkg::DEV_ADDR_HI;
      bit_cnt <= '0;
      ack_drive <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= i2c10_pkg::DEV_IDLE; // RULE_13
      bit_cnt <= '0;
      ack_drive <= 1'b0;
    end
    else if (state != i2c10_pkg::DEV_IDLE)
    begin
      if (scl_rise && bit_cnt < `BIT_ACK)
      begin
        shift <= {shift[6:0], sda_sync[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_rise && bit_cnt == `BIT_ACK)
      begin
        bit_cnt <= `BIT_ACK_END;
      end
      if (byte_fall)
      begin
        ack_drive <= acked_now; // RULE_10
      end
      if (ack_fall)
      begin
        ack_drive <= 1'b0;
        bit_cnt <= '0;
        // A refused byte drops the device off the bus until the next Start
        if (!ack_drive)
        begin
          state <= i2c10_pkg::DEV_IDLE; // RULE_08
        end
        else if (state == i2c10_pkg::DEV_ADDR_HI)
        begin
          state <= i2c10_pkg::DEV_ADDR_LO;
        end
        else if (state == i2c10_pkg::DEV_ADDR_LO)
        begin
          state <= i2c10_pkg::DEV_DATA;
        end
      end
    end
  end

  // Software-owned control; hardware clears of the release bit come last and win
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      address_match_reg <= ADDR_RESET;
      {clock_release_bit, start_ie, data_hold_enable, address_hold_enable,
       stretch_enable} <= `CTL_RESET;
      ua_wait <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `REG_ADDR_MATCH)
      begin
        address_match_reg <= reg_wdata_in[7:0];
        ua_wait <= 1'b0; // RULE_05
      end
      if (reg_wr_in && reg_addr_in == `REG_CONTROL)
      begin
        stretch_enable <= reg_wdata_in[`CTL_STRETCH];
        address_hold_enable <= reg_wdata_in[`CTL_ADDR_HOLD];
        data_hold_enable <= reg_wdata_in[`CTL_DATA_HOLD];
        start_ie <= reg_wdata_in[`CTL_START_IE];
        clock_release_bit <= reg_wdata_in[`CTL_CLK_RELEASE]; // RULE_12
      end
      if (ack_fall && ack_drive && is_addr)
      begin
        ua_wait <= 1'b1; // RULE_05
      end
      if (hold_now || (ack_fall && ack_drive && state == i2c10_pkg::DEV_DATA
                       && stretch_enable))
      begin
        clock_release_bit <= 1'b0; // RULE_11
      end
    end
  end

  // Sticky flags: write one clears IF and UA, a same-cycle set wins; Start and Stop clear each other
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      port_interrupt_flag <= 1'b0;
      update_address_flag <= 1'b0;
      start_flag <= 1'b0;
      stop_flag <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `REG_STATUS)
      begin
        port_interrupt_flag <= port_interrupt_flag & ~reg_wdata_in[`ST_IF];
        update_address_flag <= update_address_flag & ~reg_wdata_in[`ST_UA];
      end
      if (start_det)
      begin
        start_flag <= 1'b1; // RULE_01
        stop_flag <= 1'b0;
      end
      if (stop_det)
      begin
        stop_flag <= 1'b1;
        start_flag <= 1'b0;
      end
      if (start_det && start_ie)
      begin
        port_interrupt_flag <= 1'b1; // RULE_01
      end
      if ((ack_fall && ack_drive) || lo_miss || hold_now)
      begin
        port_interrupt_flag <= 1'b1; // RULE_03 RULE_08 RULE_10
      end
      if (byte_fall && ((state == i2c10_pkg::DEV_ADDR_HI && hi_match)
                        || state == i2c10_pkg::DEV_ADDR_LO))
      begin
        update_address_flag <= 1'b1; // RULE_02 RULE_07 RULE_08
      end
    end
  end

  // Accepted bytes wait here while the FIFO is full, which stretches SCL
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      push_pending <= 1'b0;
      push_data <= '0;
    end
    else if (byte_fall && acked_now)
    begin
      push_pending <= 1'b1; // RULE_04
      push_data <= shift;
    end
    else if (fifo_in_ready)
    begin
      push_pending <= 1'b0;
    end
  end

  i2c10_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_data_in(push_data),
    .in_valid_in(push_pending),
    .in_ready_out(fifo_in_ready),
    .out_data_out(fifo_data),
    .out_valid_out(buffer_full_flag),
    .out_ready_in(buf_pop)
  );

  assign buf_pop = reg_rd_in && (reg_addr_in == `REG_RX_BUF); // RULE_04

  // Clock hold only grabs a line that is already low, never cuts a high phase
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      scl_drv <= 1'b0;
    end
    else
    begin
      scl_drv <= (ua_wait || !clock_release_bit || push_pending) // RULE_05 RULE_11
                 && (scl_drv || !scl_sync[1]);
    end
  end

  assign link.dev_scl_o = 1'b0;
  assign link.dev_scl_oe = scl_drv;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = ack_drive; // RULE_10

  // Read data stands in the cycle after the strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= '0;
    end
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `REG_ADDR_MATCH: reg_rdata_out <= {8'h00, address_match_reg};
        `REG_CONTROL: reg_rdata_out <= {11'h000, clock_release_bit, start_ie,
                                        data_hold_enable, address_hold_enable,
                                        stretch_enable};
        `REG_STATUS: reg_rdata_out <= {11'h000, stop_flag, start_flag, buffer_full_flag,
                                       update_address_flag, port_interrupt_flag};
        `REG_RX_BUF: reg_rdata_out <= buffer_full_flag ? {8'h00, fifo_data} : '0;
      endcase
    end
    else
    begin
      reg_rdata_out <= '0;
    end
  end
endmodule // i2c10_slave_end
`default_nettype wire

/* File: verilog/i2c10_master_end.sv */
// Bus master end: start, eight bits, ack sample, stop, honours clock stretching
`default_nettype none
`include "i2c10_regs.svh"

module i2c10_master_end #(
  parameter int HALF_CYCLES = `HALF_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [`REG_AW-1:0] reg_addr_in,
  input wire logic [`REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`REG_DW-1:0] reg_rdata_out,
  i2c10_link_if.mst link
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  i2c10_pkg::mst_state_t state;
  logic [7:0] cnt;
  logic [3:0] bit_idx;
  logic [7:0] tx_byte;
  logic want_stop;
  logic nack;
  logic scl_oe;
  logic sda_oe;
  logic pend;
  logic [9:0] pend_cmd;
  logic take;
  logic tick;

  // Line inputs pass two flops; only the second stage is read
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end
    else
    begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  assign tick = cnt == 8'(HALF_CYCLES - 1);
  assign take = pend && (state == i2c10_pkg::M_IDLE || state == i2c10_pkg::M_HOLD);

  // One command slot; a write while it is full is dropped
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pend <= 1'b0;
      pend_cmd <= '0;
    end
    else if (reg_wr_in && reg_addr_in == `MREG_CMD && !pend)
    begin
      pend <= 1'b1;
      pend_cmd <= reg_wdata_in[9:0];
    end
    else if (take)
    begin
      pend <= 1'b0;
    end
  end

  // Bit engine; high phases count only once SCL is seen high, so stretch pauses it
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= i2c10_pkg::M_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      tx_byte <= '0;
      want_stop <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      cnt <= tick ? '0 : cnt + 8'h01;
      unique case (state)
        i2c10_pkg::M_IDLE, i2c10_pkg::M_HOLD:
        begin
          cnt <= '0;
          if (take)
          begin
            tx_byte <= pend_cmd[7:0];
            want_stop <= pend_cmd[`CMD_STOP];
            bit_idx <= '0;
            if (state == i2c10_pkg::M_IDLE)
            begin
              state <= i2c10_pkg::M_START;
            end
            else if (pend_cmd[`CMD_START])
            begin
              sda_oe <= 1'b0;
              state <= i2c10_pkg::M_RSTART;
            end
            else
            begin
              state <= i2c10_pkg::M_LOW;
            end
          end
        end
        i2c10_pkg::M_RSTART:
        begin
          if (tick)
          begin
            scl_oe <= 1'b0;
            state <= i2c10_pkg::M_START;
          end
        end
        i2c10_pkg::M_START:
        begin
          if (!scl_sync[1])
          begin
            cnt <= '0;
          end
          else if (tick)
          begin
            sda_oe <= 1'b1;
            state <= i2c10_pkg::M_SHOLD;
          end
        end
        i2c10_pkg::M_SHOLD:
        begin
          if (tick)
          begin
            scl_oe <= 1'b1;
            state <= i2c10_pkg::M_LOW;
          end
        end
        i2c10_pkg::M_LOW:
        begin
          // Data changes two cycles into the low phase, never beside an SCL edge
          if (cnt == 8'h01)
          begin
            sda_oe <= (bit_idx == `BIT_ACK) ? 1'b0 : !tx_byte[7];
          end
          if (tick)
          begin
            scl_oe <= 1'b0;
            state <= i2c10_pkg::M_HIGH;
          end
        end
        i2c10_pkg::M_HIGH:
        begin
          if (!scl_sync[1])
          begin
            cnt <= '0;
          end
          else if (tick)
          begin
            scl_oe <= 1'b1;
            if (bit_idx == `BIT_ACK)
            begin
              nack <= sda_sync[1];
              state <= i2c10_pkg::M_END;
            end
            else
            begin
              bit_idx <= bit_idx + 4'h1;
              tx_byte <= {tx_byte[6:0], 1'b0};
              state <= i2c10_pkg::M_LOW;
            end
          end
        end
        i2c10_pkg::M_END:
        begin
          if (cnt == 8'h01)
          begin
            sda_oe <= want_stop;
          end
          if (tick)
          begin
            scl_oe <= !want_stop;
            state <= want_stop ? i2c10_pkg::M_STOP : i2c10_pkg::M_HOLD;
          end
        end
        i2c10_pkg::M_STOP:
        begin
          if (!scl_sync[1])
          begin
            cnt <= '0;
          end
          else if (tick)
          begin
            sda_oe <= 1'b0;
            state <= i2c10_pkg::M_IDLE;
          end
        end
      endcase
    end
  end

  assign link.mst_scl_o = 1'b0;
  assign link.mst_scl_oe = scl_oe;
  assign link.mst_sda_o = 1'b0;
  assign link.mst_sda_oe = sda_oe;

  // Status readback one cycle after the strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= '0;
    end
    else if (reg_rd_in && reg_addr_in == `MREG_STATUS)
    begin
      reg_rdata_out <= {13'h0000, state == i2c10_pkg::M_HOLD, nack,
                        pend || !(state == i2c10_pkg::M_IDLE || state == i2c10_pkg::M_HOLD)};
    end
    else
    begin
      reg_rdata_out <= '0;
    end
  end
endmodule // i2c10_master_end
`default_nettype wire

/* File: tb/i2c10_link_asserts.sv */
// Wire-level checker for the link between the bus master end and the receiving end
`default_nettype none
module i2c10_link_asserts (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic in_frame;

  // Previous line levels; preset high so a release of reset never looks like an edge
  always_ff @(posedge ref_clk_in)
  begin
    scl_q <= sys_rst_in ? 1'b1 : scl;
    sda_q <= sys_rst_in ? 1'b1 : sda;
  end

  // Clock rises since the last Start, wrapping after the ninth (acknowledge) clock
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || (scl && scl_q && sda_q && !sda))
      bit_cnt <= 4'h0;
    else if (scl && !scl_q)
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
  end

  // Between a Start and a Stop
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || (scl && scl_q && !sda_q && sda))
      in_frame <= 1'b0;
    else if (scl && scl_q && sda_q && !sda)
      in_frame <= 1'b1;
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence start_seq;
    scl && scl_q && sda_q && !sda;
  endsequence
  sequence stop_seq;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence ack_begin;
    $rose(dev_sda_oe);
  endsequence

  chk_ack_bit_slot: assert property (ack_begin |-> bit_cnt == 4'h8 && !scl)
    else $error("receiver acknowledge outside the ninth clock low phase");
  chk_ack_full_width: assert property (ack_begin |-> dev_sda_oe [*5])
    else $error("receiver acknowledge released too early");
  chk_ack_in_frame: assert property (ack_begin |-> in_frame)
    else $error("receiver acknowledge outside a Start to Stop frame");
  chk_dev_sda_quiet: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("receiver changed SDA while SCL high");
  chk_stretch_low_only: assert property ($rose(dev_scl_oe) |-> !scl)
    else $error("receiver pulled SCL down during a high phase");
  chk_ack_slot_free: assert property ($rose(scl) && bit_cnt == 4'h8 |-> !mst_sda_oe)
    else $error("master drives SDA in the acknowledge slot");
  chk_start_setup: assert property (start_seq |-> scl [*3])
    else $error("SCL fell too soon after Start");
  chk_stop_idle: assert property (stop_seq |-> !mst_scl_oe [*4])
    else $error("master pulled SCL after Stop");
endmodule // i2c10_link_asserts
`default_nettype wire

/* File: tb/i2c_slave_ten_bit_address_rx_tb.sv */
// Self-checking bench: master end drives the receiving end across the link interface
`default_nettype none
`include "i2c10_regs.svh"
module i2c_slave_ten_bit_address_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [`REG_AW-1:0] reg_addr = '0;
  logic [`REG_DW-1:0] reg_wdata = '0;
  logic s_wr = 1'b0;
  logic s_rd = 1'b0;
  logic m_wr = 1'b0;
  logic m_rd = 1'b0;
  logic [`REG_DW-1:0] s_rdata;
  logic [`REG_DW-1:0] m_rdata;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  i2c10_link_if link ();
  i2c10_slave_end i2c10_slave_end_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(s_wr), .reg_rd_in(s_rd),
    .reg_rdata_out(s_rdata), .link(link.dev));
  i2c10_master_end i2c10_master_end_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(m_wr), .reg_rd_in(m_rd),
    .reg_rdata_out(m_rdata), .link(link.mst));
  i2c10_link_asserts i2c10_link_asserts_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .scl(link.scl), .sda(link.sda), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_oe(link.dev_sda_oe), .mst_scl_oe(link.mst_scl_oe),
    .mst_sda_oe(link.mst_sda_oe));

  // 40 MHz system clock
  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang in a handshake ends the run here rather than spinning forever
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; m selects the master end
  task automatic wr(input bit m, input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    if (m) m_wr <= 1'b1; else s_wr <= 1'b1;
    @(posedge ref_clk_in);
    m_wr <= 1'b0;
    s_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input bit m, input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    if (m) m_rd <= 1'b1; else s_rd <= 1'b1;
    @(posedge ref_clk_in);
    m_rd <= 1'b0;
    s_rd <= 1'b0;
    #1 d = m ? m_rdata : s_rdata;
  endtask

  task automatic rdchk(input bit m, input logic [1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(m, a, d);
    chk(d, exp);
  endtask

  // Hands one byte command to the master, waits for it to finish, checks the ack
  task automatic send(input logic [15:0] cmd, input logic nack);
    logic [15:0] d;
    int n;
    wr(1'b1, `MREG_CMD, cmd);
    repeat (2) @(posedge ref_clk_in);
    d = 16'h0001;
    for (n = 0; n < 3000 && d[`MST_BUSY]; n++)
      rd(1'b1, `MREG_STATUS, d);
    // The receiver sees the lines a few cycles after the master; let a Stop land
    repeat (4) @(posedge ref_clk_in);
    chk({15'h0000, d[`MST_BUSY]}, 16'h0000);
    chk({15'h0000, d[`MST_NACK]}, {15'h0000, nack});
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rdchk(1'b0, `REG_ADDR_MATCH, 16'h00f0);
    rdchk(1'b0, `REG_CONTROL, 16'h0010);
    rdchk(1'b0, `REG_STATUS, 16'h0000);
    rdchk(1'b1, `MREG_STATUS, 16'h0000);
    $display("test reset values done");
    send(16'h01f0, 1'b0);
    rdchk(1'b0, `REG_STATUS, 16'h000f);
    wr(1'b0, `REG_STATUS, 16'h0003);
    rdchk(1'b0, `REG_RX_BUF, 16'h00f0);
    rdchk(1'b0, `REG_STATUS, 16'h0008);
    wr(1'b0, `REG_ADDR_MATCH, 16'h005a);
    send(16'h005a, 1'b0);
    rdchk(1'b0, `REG_STATUS, 16'h000f);
    wr(1'b0, `REG_STATUS, 16'h0003);
    rdchk(1'b0, `REG_RX_BUF, 16'h005a);
    wr(1'b0, `REG_ADDR_MATCH, 16'h00f0);
    $display("test address match done");
    wr(1'b0, `REG_CONTROL, 16'h0011);
    send(16'h00a5, 1'b0);
    rdchk(1'b0, `REG_CONTROL, 16'h0001);
    rdchk(1'b0, `REG_STATUS, 16'h000d);
    rdchk(1'b0, `REG_RX_BUF, 16'h00a5);
    // Stretching off before the last byte, else the hold would block the Stop
    wr(1'b0, `REG_CONTROL, 16'h0010);
    wr(1'b0, `REG_STATUS, 16'h0003);
    send(16'h023c, 1'b0);
    rdchk(1'b0, `REG_STATUS, 16'h0015);
    rdchk(1'b0, `REG_RX_BUF, 16'h003c);
    $display("test stretched data done");
    send(16'h01f0, 1'b0);
    wr(1'b0, `REG_STATUS, 16'h0003);
    rdchk(1'b0, `REG_RX_BUF, 16'h00f0);
    wr(1'b0, `REG_ADDR_MATCH, 16'h005a);
    send(16'h0233, 1'b1);
    rdchk(1'b0, `REG_STATUS, 16'h0013);
    rdchk(1'b0, `REG_CONTROL, 16'h0010);
    rdchk(1'b0, `REG_RX_BUF, 16'h0000);
    wr(1'b0, `REG_ADDR_MATCH, 16'h00f0);
    wr(1'b0, `REG_STATUS, 16'h0003);
    send(16'h03f1, 1'b1);
    rdchk(1'b0, `REG_STATUS, 16'h0010);
    $display("test refused addresses done");
    send(16'h01f0, 1'b0);
    wr(1'b0, `REG_ADDR_MATCH, 16'h005a);
    send(16'h005a, 1'b0);
    wr(1'b0, `REG_ADDR_MATCH, 16'h00f0);
    rdchk(1'b0, `REG_RX_BUF, 16'h00f0);
    rdchk(1'b0, `REG_RX_BUF, 16'h005a);
    // Seventeen bytes into a sixteen-deep buffer: the last waits behind the hold
    for (int i = 0; i < 16; i++)
      send({8'h00, 8'(i)}, 1'b0);
    // The ack clock of the last byte stalls until a read makes room
    wr(1'b1, `MREG_CMD, 16'h0010);
    repeat (200) @(posedge ref_clk_in);
    rdchk(1'b1, `MREG_STATUS, 16'h0001);
    for (int i = 0; i < 17; i++)
      rdchk(1'b0, `REG_RX_BUF, {8'h00, 8'(i)});
    rdchk(1'b0, `REG_RX_BUF, 16'h0000);
    // Data hold stops the clock before the ack until the release bit is set
    wr(1'b0, `REG_CONTROL, 16'h0014);
    wr(1'b1, `MREG_CMD, 16'h0066);
    repeat (200) @(posedge ref_clk_in);
    rdchk(1'b0, `REG_CONTROL, 16'h0004);
    rdchk(1'b1, `MREG_STATUS, 16'h0001);
    wr(1'b0, `REG_CONTROL, 16'h0010);
    repeat (100) @(posedge ref_clk_in);
    rdchk(1'b1, `MREG_STATUS, 16'h0004);
    rdchk(1'b0, `REG_RX_BUF, 16'h0066);
    send(16'h0277, 1'b0);
    rdchk(1'b0, `REG_RX_BUF, 16'h0077);
    wr(1'b0, `REG_CONTROL, 16'h0018);
    wr(1'b0, `REG_STATUS, 16'h0003);
    send(16'h03f1, 1'b1);
    rdchk(1'b0, `REG_STATUS, 16'h0011);
    $display("test buffer fill done");
    tally_and_finish();
  end
endmodule // i2c_slave_ten_bit_address_rx_tb
`default_nettype wire
